// ==== adcc_ctrl.sv ====
// Both control registers of the ADC with readback, calibration and data-ready logic
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

//
// Contract
// - Writing 1 to bit 0 resets both registers, FIFO pointer and offset.
// - After reset, five conversion clocks pass before the first stored sample.
// - Bit 1 reads 1 after a FIFO overflow, else 0.
// - The overflow flag clears once this register is read.
// - Writing 1 to bit 1 resets the FIFO.
// - Bits 2 and 3 pick the fill threshold that raises data-ready.
// - Bit 4 picks level (0) or pulse (1) data-ready.
// - Bit 5 picks data-ready polarity: 1 high active, 0 low active.
// - Bit 6 set: write pin is read/write direction, read pin ignored.
// - Bit 6 clear: separate read and write strobes are used.
// - Bit 7 picks two's complement (0) or straight binary (1).
// - Writing 1 to bit 8 zeroes inputs, converts once, stores offset.
// - The stored offset is subtracted from every later result.
// - Bit 9 set: first read returns register 0, second register 1.
// - Thresholds 1,4,8,14 for one channel; 2,4,8,12 for two, 3,6,9,12 for three, 4,8,12,16 for four.
// - Level data-ready drops at first read, rearms after threshold reads.
// - Pulse lasts half a conversion clock; next waits for batch read.
module adcc_ctrl (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Host port pins
   input wire adcc_pkg::adcc_pins_s pins,
   input wire logic [11:0] data_i,
   output logic [11:0] data_o,
   output logic data_oe_n,
   // Conversion clock pin
   input wire logic sample_clock_in,
   // Conversion engine
   input wire logic conv_valid,
   input wire logic [11:0] conv_raw,
   output logic zero_input,
   output logic [9:0] cfg_cr0,
   // FIFO
   input wire logic [4:0] fifo_count,
   input wire logic fifo_overrun_evt,
   input wire logic [11:0] fifo_rd_data,
   output logic fifo_rd_en,
   output logic fifo_wr_en,
   output logic [11:0] fifo_wr_data,
   output logic fifo_clear,
   // Data-ready pin
   output logic samples_ready_out
);
   import adcc_pkg::*;

   adcc_access_s acc;
   adcc_cr1_s cr1;
   adcc_cal_e cal;
   adcc_config_readback_en_e rb;
   logic conv_rise;
   logic conv_fall;
   logic [9:0] cr0;
   logic fifo_overrun_flag;
   logic [11:0] offset;
   logic [2:0] startup_cnt;
   logic started;
   logic wr_cr0;
   logic wr_cr1;
   logic soft_rst;
   logic rd_cr1;
   logic [4:0] threshold_count;
   logic armed;
   logic trigger;
   logic [4:0] reads_left;
   logic level_on;
   logic pulse_pend;
   logic pulse_on;

   // ----------------------------------------
   // Helper functions
   // ----------------------------------------
   // Offset removal and output number format
   function automatic logic [11:0] adcc_format(input logic [11:0] raw, input logic [11:0] off,
                                               input logic bin);
      logic [11:0] diff;
      diff = raw - off;
      adcc_format = bin ? (diff ^ `ADCC_SIGN_FLIP) : diff;
   endfunction : adcc_format

   // Channel count minus one from the channel field of register 0
   function automatic logic [1:0] adcc_chan_idx(input logic [9:0] c0);
      case (c0[`ADCC_CR0_CH_HI:`ADCC_CR0_CH_LO])
         `ADCC_SCAN_2SE, `ADCC_SCAN_1D1SE, `ADCC_SCAN_2D: adcc_chan_idx = 2'h1;
         `ADCC_SCAN_3SE, `ADCC_SCAN_1D2SE: adcc_chan_idx = 2'h2;
         `ADCC_SCAN_4SE: adcc_chan_idx = 2'h3;
         default: adcc_chan_idx = 2'h0;
      endcase
   endfunction : adcc_chan_idx

   // Fill threshold from channel count and select code
   function automatic logic [4:0] adcc_level(input logic [1:0] ch, input logic [1:0] sel);
      logic [79:0] tbl;
      logic [6:0] pos;
      tbl = `ADCC_LEVEL_TABLE;
      pos = 7'({ch, sel}) * 7'h05;
      adcc_level = tbl[pos +: 5];
   endfunction : adcc_level

   // ----------------------------------------
   // Host port
   // ----------------------------------------
   adcc_pin_sync u_pin_sync (
      .mclk(mclk),
      .rst(rst),
      .ce(ce),
      .pins(pins),
      .data_i(data_i),
      .sample_clock_in(sample_clock_in),
      .rw_combined(cr1.rw_combined),
      .acc(acc),
      .conv_rise(conv_rise),
      .conv_fall(conv_fall)
   );

   // Read and write decode
   always_comb begin
      wr_cr0 = acc.wr_done && (acc.reg_sel == `ADCC_SEL_CR0);
      wr_cr1 = acc.wr_done && (acc.reg_sel == `ADCC_SEL_CR1);
      soft_rst = wr_cr1 && acc.wr_data[`ADCC_BIT_RESET];
      rd_cr1 = acc.rd_start && (rb == rb_cr1);
      fifo_rd_en = acc.rd_start && (rb == rb_off);
      data_oe_n = !acc.rd_active;
      cfg_cr0 = cr0;
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cr0 <= `ADCC_CR0_RST;
         cr1 <= `ADCC_CR1_RST;
      end else if (ce) begin
         if (soft_rst) begin
            cr0 <= `ADCC_CR0_RST;
            cr1 <= `ADCC_CR1_RST;
         end else if (wr_cr0) begin
            cr0 <= acc.wr_data[9:0];
         end else if (wr_cr1) begin
            cr1 <= acc.wr_data[`ADCC_CR1_STORED_HI:`ADCC_CR1_STORED_LO];
         end
      end
   end

   // FIFO clear strobe, one cycle, never stored
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fifo_clear <= 1'b0;
      end else if (ce) begin
         fifo_clear <= wr_cr1 && (acc.wr_data[`ADCC_BIT_FIFO_CLR] || soft_rst);
      end
   end

   // Overflow flag, a new overflow wins over the clearing read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fifo_overrun_flag <= 1'b0;
      end else if (ce) begin
         if (fifo_overrun_evt) begin
            fifo_overrun_flag <= 1'b1;
         end else if (rd_cr1 || soft_rst) begin
            fifo_overrun_flag <= 1'b0;
         end
      end
   end

   // Readback sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rb <= rb_off;
      end else if (ce) begin
         if (soft_rst) begin
            rb <= rb_off;
         end else if (wr_cr1 && acc.wr_data[`ADCC_BIT_READBACK]) begin
            rb <= rb_cr0;
         end else if (acc.rd_start) begin
            unique case (rb)
               rb_cr0: rb <= rb_cr1;
               rb_cr1: rb <= rb_off;
               rb_off: rb <= rb_off;
            endcase
         end
      end
   end

   // Read data, loaded at the start of each read
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         data_o <= 12'h000;
      end else if (acc.rd_start) begin
         unique case (rb)
            rb_cr0: data_o <= {2'h0, cr0};
            rb_cr1: data_o <= {2'h0, cr1, fifo_overrun_flag, 1'b0};
            rb_off: data_o <= fifo_rd_data;
         endcase
      end
   end

   // ----------------------------------------
   // Conversion path
   // ----------------------------------------
   // Start-up wait counted in conversion clock periods
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         startup_cnt <= 3'h0;
      end else if (ce) begin
         if (soft_rst) begin
            startup_cnt <= 3'h0;
         end else if (conv_rise && !started) begin
            startup_cnt <= startup_cnt + 3'h1;
         end
      end
   end

   assign started = (startup_cnt == `ADCC_START_WAIT);

   // Offset calibration sequencer
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         cal <= cal_idle;
         offset <= `ADCC_OFFSET_RST;
      end else if (ce) begin
         if (soft_rst) begin
            cal <= cal_idle;
            offset <= `ADCC_OFFSET_RST;
         end else begin
            unique case (cal)
               cal_idle: if (wr_cr1 && acc.wr_data[`ADCC_BIT_CAL]) begin
                  cal <= cal_wait;
               end
               cal_wait: if (conv_valid && started) begin
                  offset <= conv_raw;
                  cal <= cal_idle;
               end
            endcase
         end
      end
   end

   assign zero_input = (cal == cal_wait);

   // Corrected samples into the FIFO
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         fifo_wr_en <= 1'b0;
         fifo_wr_data <= 12'h000;
      end else if (ce) begin
         fifo_wr_en <= conv_valid && started && (cal == cal_idle) && !soft_rst;
         if (conv_valid) begin
            fifo_wr_data <= adcc_format(conv_raw, offset, cr1.number_format_sel);
         end
      end
   end

   // ----------------------------------------
   // Data-ready output
   // ----------------------------------------
   assign threshold_count = adcc_level(adcc_chan_idx(cr0),
                                       {cr1.threshold_sel_hi, cr1.threshold_sel_lo});
   assign trigger = armed && (fifo_count >= threshold_count);

   // Trigger, batch tracking and level state
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         armed <= 1'b1;
         reads_left <= 5'h00;
         level_on <= 1'b0;
      end else if (ce) begin
         if (soft_rst || fifo_clear) begin
            armed <= 1'b1;
            reads_left <= 5'h00;
            level_on <= 1'b0;
         end else if (trigger) begin
            armed <= 1'b0;
            reads_left <= threshold_count;
            level_on <= 1'b1;
         end else if (!armed && fifo_rd_en) begin
            level_on <= 1'b0;
            reads_left <= reads_left - 5'h01;
            armed <= (reads_left == 5'h01);
         end
      end
   end

   // Pulse of half a conversion clock, rising to falling edge
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pulse_pend <= 1'b0;
         pulse_on <= 1'b0;
      end else if (ce) begin
         if (soft_rst || fifo_clear) begin
            pulse_pend <= 1'b0;
            pulse_on <= 1'b0;
         end else if (trigger) begin
            pulse_pend <= 1'b1;
         end else if (conv_rise && pulse_pend) begin
            pulse_pend <= 1'b0;
            pulse_on <= 1'b1;
         end else if (conv_fall) begin
            pulse_on <= 1'b0;
         end
      end
   end

   // Type and polarity applied to the pin
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         samples_ready_out <= 1'b0;
      end else if (ce) begin
         samples_ready_out <= (cr1.ready_pulse ? pulse_on : level_on) ~^ cr1.ready_pol;
      end
   end

   // ----------------------------------------
   // Assertions
   // ----------------------------------------
   sequence s_rb_first;
      ce && acc.rd_start && (rb == rb_cr0);
   endsequence

   sequence s_rb_second;
      ce && acc.rd_start && (rb == rb_cr1);
   endsequence

   a_soft_reset_regs: assert property (@(posedge mclk) disable iff (rst)
      ce && soft_rst |=> (cr1 == `ADCC_CR1_RST) && (cr0 == `ADCC_CR0_RST) && (offset == 12'h000))
      else $error("soft reset left register state");

   a_start_wait_gate: assert property (@(posedge mclk) disable iff (rst)
      fifo_wr_en |-> $past(startup_cnt) == `ADCC_START_WAIT)
      else $error("sample stored before start-up wait");

   a_overrun_set: assert property (@(posedge mclk) disable iff (rst)
      ce && fifo_overrun_evt |=> fifo_overrun_flag)
      else $error("overflow not flagged");

   a_overrun_clear: assert property (@(posedge mclk) disable iff (rst)
      ce && rd_cr1 && !fifo_overrun_evt |=> !fifo_overrun_flag)
      else $error("overflow flag survived read");

   a_fifo_clear_strobe: assert property (@(posedge mclk) disable iff (rst)
      ce && wr_cr1 && acc.wr_data[`ADCC_BIT_FIFO_CLR] |=> fifo_clear ##1 (!ce || !fifo_clear))
      else $error("fifo clear not a single strobe");

   a_level_first_read: assert property (@(posedge mclk) disable iff (rst)
      ce && !cr1.ready_pulse && level_on && fifo_rd_en && !trigger && !soft_rst && !fifo_clear
      |=> !level_on ##1 (!ce || samples_ready_out == !cr1.ready_pol))
      else $error("level data-ready kept after first read");

   a_pulse_half_clk: assert property (@(posedge mclk) disable iff (rst)
      ce && pulse_on && conv_fall && !trigger |=> !pulse_on)
      else $error("pulse outlived half conversion clock");

   a_offset_subtract: assert property (@(posedge mclk) disable iff (rst)
      ce && conv_valid |=> fifo_wr_data ==
         adcc_format($past(conv_raw), $past(offset), $past(cr1.number_format_sel)))
      else $error("stored sample not offset corrected");

   a_cal_capture: assert property (@(posedge mclk) disable iff (rst)
      ce && (cal == cal_wait) && conv_valid && started && !soft_rst
      |=> (offset == $past(conv_raw)) && !zero_input)
      else $error("calibration result not stored");

   a_config_readback_en_order: assert property (@(posedge mclk) disable iff (rst)
      s_rb_first |=> (data_o == {2'h0, $past(cr0)}) && (rb == rb_cr1))
      else $error("first readback not register 0");

   a_config_readback_en_second: assert property (@(posedge mclk) disable iff (rst)
      s_rb_second |=> (data_o[11:2] == {2'h0, $past(cr1)}) && (rb == rb_off))
      else $error("second readback not register 1");

endmodule : adcc_ctrl
`default_nettype wire

// ==== adcc_ctrl_tb.sv ====
// Self-checking bench for the ADC control bank
`timescale 1ns/1ps
`default_nettype none

module adcc_ctrl_tb;
   import adcc_pkg::*;
   localparam logic [11:0] OFS = 12'h005;
   localparam logic [11:0] SIG = 12'h105;
   logic mclk = 1'b0;
   logic rst = 1'b1;
   logic sclk = 1'b0;
   logic comb = 1'b0;
   logic pol = 1'b0;
   adcc_pins_s pins = 5'h16;
   logic [11:0] data_i = 12'h000;
   logic [11:0] data_o, conv_raw, fifo_rd_data, fifo_wr_data, d;
   logic [9:0] cfg_cr0;
   logic [4:0] fifo_count;
   logic data_oe_n, conv_valid, zero_input, fifo_overrun_evt;
   logic fifo_rd_en, fifo_wr_en, fifo_clear, samples_ready_out;
   int errors = 0;
   int n_compared = 0;
   int act = 0;
   int cyc = 0;
   int levels[4] = '{1, 4, 8, 14};

   adcc_ctrl i_adcc_ctrl (.mclk(mclk), .rst(rst), .ce(1'b1), .pins(pins), .data_i(data_i),
      .data_o(data_o), .data_oe_n(data_oe_n), .sample_clock_in(sclk), .conv_valid(conv_valid),
      .conv_raw(conv_raw), .zero_input(zero_input), .cfg_cr0(cfg_cr0),
      .fifo_count(fifo_count), .fifo_overrun_evt(fifo_overrun_evt),
      .fifo_rd_data(fifo_rd_data), .fifo_rd_en(fifo_rd_en), .fifo_wr_en(fifo_wr_en),
      .fifo_wr_data(fifo_wr_data), .fifo_clear(fifo_clear),
      .samples_ready_out(samples_ready_out));

   adcc_fifo_model #(.OFS(OFS), .SIG(SIG)) i_adcc_fifo_model (.mclk(mclk), .rst(rst),
      .sample_clock_in(sclk), .zero_input(zero_input), .conv_valid(conv_valid),
      .conv_raw(conv_raw), .fifo_wr_en(fifo_wr_en), .fifo_wr_data(fifo_wr_data),
      .fifo_rd_en(fifo_rd_en), .fifo_clear(fifo_clear), .fifo_count(fifo_count),
      .fifo_overrun_evt(fifo_overrun_evt), .fifo_rd_data(fifo_rd_data));

   // Clock, cycle ceiling and active-cycle count of the data-ready pin
   always #20 mclk = ~mclk;
   always @(posedge mclk) begin
      act = act + ((samples_ready_out === pol) ? 1 : 0);
      cyc++;
      if (cyc == 6000) begin
         errors++;
         stop_test();
      end
   end

   // ----------------------------------------
   // Bus and comparison tasks
   // ----------------------------------------
   task automatic stop_test();
      if (errors == 0 && n_compared > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : stop_test

   task automatic check(input logic [11:0] seen, input logic [11:0] exp);
      n_compared++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic idle(input int n);
      repeat (n) @(negedge mclk);
   endtask : idle

   // Write strobe low with read strobe high suits both strobe modes
   task automatic bus_write(input logic sel, input logic [11:0] v);
      pins = '{cs0_n: 1'b0, cs1: 1'b1, rd_n: 1'b1, wr_n: 1'b0, reg_sel: sel};
      data_i = v;
      idle(4);
      pins = 5'h16;
      idle(6);
   endtask : bus_write

   // Combined mode reads with the read strobe left high
   task automatic bus_read(output logic [11:0] v);
      pins = '{cs0_n: 1'b0, cs1: 1'b1, rd_n: comb, wr_n: 1'b1, reg_sel: 1'b1};
      idle(5);
      v = data_o;
      check({11'h000, data_oe_n}, 12'h000);
      pins = 5'h16;
      idle(6);
      check({11'h000, data_oe_n}, 12'h001);
   endtask : bus_read

   // Conversion clock runs only while samples are wanted
   task automatic run(input int n);
      repeat (n) begin
         sclk = 1'b1;
         idle(5);
         sclk = 1'b0;
         idle(5);
      end
   endtask : run

   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      idle(16);
      rst = 1'b0;
      idle(2);
      check({2'b00, cfg_cr0}, 12'h000);
      check({11'h000, samples_ready_out}, 12'h000);
      // Start-up delay before the first stored sample
      run(4);
      check({7'h00, fifo_count}, 12'h000);
      run(2);
      check({11'h000, fifo_count != 5'h00}, 12'h001);
      // Offset calibration, FIFO clear, number format
      bus_write(1'b1, 12'h130);
      check({11'h000, zero_input}, 12'h001);
      run(2);
      check({11'h000, zero_input}, 12'h000);
      bus_write(1'b1, 12'h032);
      check({7'h00, fifo_count}, 12'h000);
      run(1);
      bus_read(d);
      check(d, SIG - OFS);
      bus_write(1'b1, 12'h0b2);
      run(1);
      bus_read(d);
      check(d, (SIG - OFS) ^ 12'h800);
      // Overflow flag seen through readback, cleared by reading it
      bus_write(1'b1, 12'h032);
      run(17);
      bus_write(1'b1, 12'h230);
      bus_read(d);
      check(d, 12'h000);
      bus_read(d);
      check(d, 12'h232);
      bus_write(1'b1, 12'h230);
      bus_read(d);
      bus_read(d);
      check(d, 12'h230);
      // Every threshold code, both polarities, level and pulse
      for (int m = 0; m < 4; m++) begin
         pol = m[0];
         bus_write(1'b1, {6'h00, m[0], m[1], m[1:0], 2'b10});
         act = 0;
         check({11'h000, samples_ready_out}, {11'h000, ~pol});
         run(levels[m] - 1);
         check({11'h000, samples_ready_out}, {11'h000, ~pol});
         run(1);
         if (m[1]) begin
            run(1);
            check(12'(act), 12'h005);
         end else begin
            check({11'h000, samples_ready_out}, {11'h000, pol});
            bus_read(d);
            check({11'h000, samples_ready_out}, {11'h000, ~pol});
         end
      end
      // Two-channel autoscan doubles the lowest threshold
      bus_write(1'b0, 12'h088);
      bus_write(1'b1, 12'h022);
      run(1);
      check({11'h000, samples_ready_out}, 12'h000);
      run(1);
      check({11'h000, samples_ready_out}, 12'h001);
      // Combined strobe mode, then soft reset back to separate strobes
      bus_write(1'b0, 12'h307);
      check({2'b00, cfg_cr0}, 12'h307);
      bus_write(1'b1, 12'h270);
      comb = 1'b1;
      bus_read(d);
      check(d, 12'h307);
      bus_read(d);
      check(d, 12'h270);
      bus_write(1'b1, 12'h001);
      check({2'b00, cfg_cr0}, 12'h000);
      comb = 1'b0;
      bus_write(1'b1, 12'h230);
      bus_read(d);
      check(d, 12'h000);
      bus_read(d);
      check(d, 12'h230);
      // Start-up wait restarts and offset is gone after soft reset
      run(4);
      check({7'h00, fifo_count}, 12'h000);
      run(1);
      bus_read(d);
      check(d, SIG);
      stop_test();
   end
endmodule : adcc_ctrl_tb
`default_nettype wire

// ==== adcc_fifo_model.sv ====
// Behavioural FIFO and conversion engine that sit beside the ADC control bank
`timescale 1ns/1ps
`default_nettype none

module adcc_fifo_model #(
   parameter logic [11:0] OFS = 12'h005,
   parameter logic [11:0] SIG = 12'h105
) (
   // Clock and reset
   input wire logic mclk,
   input wire logic rst,
   // Conversion engine side
   input wire logic sample_clock_in,
   input wire logic zero_input,
   output logic conv_valid,
   output logic [11:0] conv_raw,
   // FIFO side
   input wire logic fifo_wr_en,
   input wire logic [11:0] fifo_wr_data,
   input wire logic fifo_rd_en,
   input wire logic fifo_clear,
   output logic [4:0] fifo_count,
   output logic fifo_overrun_evt,
   output logic [11:0] fifo_rd_data
);
   logic [11:0] mem [16];
   logic [3:0] wp;
   logic [3:0] rp;
   logic [4:0] dly;
   logic wr_ok;
   logic rd_ok;

   // Result appears four mclk after each conversion clock rise
   always @(posedge mclk or posedge rst) begin
      if (rst) begin
         dly <= 5'h00;
      end else begin
         dly <= {dly[3:1], sample_clock_in & ~dly[0], sample_clock_in};
      end
   end
   assign conv_valid = dly[4];
   // Forced-zero input converts to the offset only
   assign conv_raw = zero_input ? OFS : SIG;

   // Sixteen-word store, overflow reported when a push meets a full store
   assign wr_ok = fifo_wr_en && (fifo_count != 5'h10);
   assign rd_ok = fifo_rd_en && (fifo_count != 5'h00);
   always @(posedge mclk or posedge rst) begin
      fifo_overrun_evt <= 1'b0;
      if (rst || fifo_clear) begin
         wp <= 4'h0;
         rp <= 4'h0;
         fifo_count <= 5'h00;
      end else begin
         if (wr_ok) begin
            mem[wp] <= fifo_wr_data;
            wp <= wp + 4'h1;
         end
         fifo_overrun_evt <= fifo_wr_en & ~wr_ok;
         if (rd_ok) begin
            rp <= rp + 4'h1;
         end
         fifo_count <= fifo_count + 5'(wr_ok) - 5'(rd_ok);
      end
   end
   // Empty store shows a changed word, not the last one
   assign fifo_rd_data = (fifo_count != 5'h00) ? mem[rp] : ~mem[rp];
endmodule : adcc_fifo_model
`default_nettype wire

// ==== adcc_map.svh ====
// Offsets, field positions, reset values and timing counts of the ADC control bank
`ifndef ADCC_MAP_SVH
`define ADCC_MAP_SVH

// Register selection on the address pin
`define ADCC_SEL_CR0 1'b0
`define ADCC_SEL_CR1 1'b1

// Field positions of the second control register
`define ADCC_BIT_RESET 0
`define ADCC_BIT_FIFO_CLR 1
`define ADCC_BIT_CAL 8
`define ADCC_BIT_READBACK 9
`define ADCC_CR1_STORED_LO 2
`define ADCC_CR1_STORED_HI 9

// Reset values
`define ADCC_CR0_RST 10'h000
`define ADCC_CR1_RST 8'h0c
`define ADCC_OFFSET_RST 12'h000
`define ADCC_PINS_IDLE 5'h16

// Conversion clock periods from reset to the first stored sample
`define ADCC_START_WAIT 3'h5

// Input channel field of the first control register and its autoscan codes
`define ADCC_CR0_CH_LO 3
`define ADCC_CR0_CH_HI 7
`define ADCC_SCAN_2SE 5'h11
`define ADCC_SCAN_3SE 5'h12
`define ADCC_SCAN_4SE 5'h13
`define ADCC_SCAN_1D1SE 5'h15
`define ADCC_SCAN_1D2SE 5'h16
`define ADCC_SCAN_2D 5'h19

// Fill thresholds, entry index = channels_minus_one * 4 + select code
`define ADCC_LEVEL_TABLE {5'h10, 5'h0c, 5'h08, 5'h04, 5'h0c, 5'h09, 5'h06, 5'h03, \
                       5'h0c, 5'h08, 5'h04, 5'h02, 5'h0e, 5'h08, 5'h04, 5'h01}

// Sign bit flip that turns two's complement into straight binary
`define ADCC_SIGN_FLIP 12'h800

`endif

// ==== adcc_pin_sync.sv ====
// Pin synchronisers and read/write strobe decoding of the ADC host port
`timescale 1ns/1ps
`default_nettype none
`include "adcc_map.svh"

module adcc_pin_sync (
   // Clock, reset, enable
   input wire logic mclk,
   input wire logic rst,
   input wire logic ce,
   // Host port pins
   input wire adcc_pkg::adcc_pins_s pins,
   input wire logic [11:0] data_i,
   input wire logic sample_clock_in,
   // Strobe mode
   input wire logic rw_combined,
   // Decoded access and conversion clock edges
   output adcc_pkg::adcc_access_s acc,
   output logic conv_rise,
   output logic conv_fall
);
   import adcc_pkg::*;

   adcc_pins_s pins_m;
   adcc_pins_s pins_s;
   logic [11:0] data_m;
   logic [11:0] data_s;
   logic clk_m;
   logic clk_s;
   logic clk_d;
   logic cs_on;
   logic rd_lvl;
   logic wr_lvl;
   logic rd_q;
   logic wr_q;
   logic sel_q;
   logic [11:0] wdata_q;

   // ----------------------------------------
   // Two-stage synchronisers
   // ----------------------------------------
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         pins_m <= `ADCC_PINS_IDLE;
         pins_s <= `ADCC_PINS_IDLE;
         data_m <= 12'h000;
         data_s <= 12'h000;
         clk_m <= 1'b0;
         clk_s <= 1'b0;
         clk_d <= 1'b0;
      end else if (ce) begin
         pins_m <= pins;
         pins_s <= pins_m;
         data_m <= data_i;
         data_s <= data_m;
         clk_m <= sample_clock_in;
         clk_s <= clk_m;
         clk_d <= clk_s;
      end
   end

   // Strobe combining, read direction wins only with write inactive
   always_comb begin
      cs_on = !pins_s.cs0_n && pins_s.cs1;
      if (rw_combined) begin
         rd_lvl = cs_on && pins_s.wr_n;
         wr_lvl = cs_on && !pins_s.wr_n;
      end else begin
         rd_lvl = cs_on && !pins_s.rd_n && pins_s.wr_n;
         wr_lvl = cs_on && !pins_s.wr_n && pins_s.rd_n;
      end
   end

   // Access history and write data capture
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         rd_q <= 1'b0;
         wr_q <= 1'b0;
         sel_q <= 1'b0;
         wdata_q <= 12'h000;
      end else if (ce) begin
         rd_q <= rd_lvl;
         wr_q <= wr_lvl;
         if (wr_lvl) begin
            sel_q <= pins_s.reg_sel;
            wdata_q <= data_s;
         end
      end
   end

   // Write commits when the access ends, reads act at their start
   always_comb begin
      acc.rd_start = rd_lvl && !rd_q && ce;
      acc.rd_active = rd_lvl;
      acc.wr_done = !wr_lvl && wr_q && ce;
      acc.reg_sel = sel_q;
      acc.wr_data = wdata_q;
      conv_rise = clk_s && !clk_d && ce;
      conv_fall = !clk_s && clk_d && ce;
   end

endmodule : adcc_pin_sync
`default_nettype wire

// ==== adcc_pkg.sv ====
// Types shared by the ADC control bank modules
package adcc_pkg;

   // Host port pins, as driven, sampled later by the synchronisers
   typedef struct packed {
      logic cs0_n;
      logic cs1;
      logic rd_n;
      logic wr_n;
      logic reg_sel;
   } adcc_pins_s;

   // Stored fields of the second control register, bits 9 down to 2
   typedef struct packed {
      logic config_readback_en;
      logic offset_cal;
      logic number_format_sel;
      logic rw_combined;
      logic ready_pol;
      logic ready_pulse;
      logic threshold_sel_hi;
      logic threshold_sel_lo;
   } adcc_cr1_s;

   // Decoded host access
   typedef struct packed {
      logic rd_start;
      logic rd_active;
      logic wr_done;
      logic reg_sel;
      logic [11:0] wr_data;
   } adcc_access_s;

   typedef enum {cal_idle, cal_wait} adcc_cal_e;

   typedef enum {rb_off, rb_cr0, rb_cr1} adcc_config_readback_en_e;

endpackage : adcc_pkg
